//--- hdl/isc_state_counter.sv
// Purpose: Cycle breakdown and execution state count per instruction.
// Assumes: Fetch, branch-address and stack cycles hit on-chip memory.
// Notes:   Two-stage pipeline: decode plus lookup, then weighted sum.
//
// Operation
// - Total states equal sum of each kind's cycles times its states.
// - Fetch, stack, branch-address and memory data cycles cost 2 states.
// - Peripheral byte or word access costs 2 or 3 states by module.
// - Each internal operation cycle costs 1 state.
// - Word immediate add and and: two fetches only.
// - Longword immediate add and and: three fetches only.
// - Adding 1, 2 or 4 to a long register needs one fetch.
// - Bit-and on register one fetch; memory forms two fetches, one byte.
// - Short-displacement branches need two fetches, taken or not.
// - Long-displacement branches need two fetches plus two internal.
// - Bit-clear on memory needs two fetches and two byte accesses.
`timescale 1ns/100ps
module isc_state_counter (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 reqValid,
  input  wire isc_pkg::isc_req_type req,
  output logic                      resValid,
  output isc_pkg::isc_res_type      res
);

  // Stage-one registers: decoded cycles and the data location.
  isc_pkg::isc_cycles_type cycles_d;
  isc_pkg::isc_cycles_type cycles_q;
  logic                    known_d;
  logic                    known_q;
  logic                    peri_d;
  logic                    peri_q;
  logic                    valid1_d;
  logic                    valid1_q;
  // Stage-two registers feed the outputs directly.
  isc_pkg::isc_res_type    res_d;
  isc_pkg::isc_res_type    res_q;
  logic                    valid2_d;
  logic                    valid2_q;
  logic [1:0]              periStates;
  logic [1:0]              dataStates;
  logic [isc_pkg::TOTAL_W-1:0] weighted [isc_pkg::KIND_COUNT];
  logic [isc_pkg::TOTAL_W-1:0] sum;
  logic [1:0]              weight [isc_pkg::KIND_COUNT];
  isc_pkg::isc_cnt_type    count  [isc_pkg::KIND_COUNT];

  // The lookup registers in step with stage one.
  isc_peri_lookup uLookup (
    .clk          (clk),
    .rst_n        (rst_n),
    .addr         (req.dataAddr),
    .accessStates (periStates)
  );

  // Decode the instruction class into counts of each cycle kind.
  always_comb begin
    cycles_d = '0;
    known_d  = 1'b1;
    peri_d   = req.dataIsPeri;
    valid1_d = reqValid;
    case (req.op)
      isc_pkg::OP_ADD_B_IMM,
      isc_pkg::OP_ADD_B_REG,
      isc_pkg::OP_ADD_W_REG,
      isc_pkg::OP_AND_B_IMM,
      isc_pkg::OP_AND_B_REG,
      isc_pkg::OP_AND_W_REG,
      isc_pkg::OP_ADDC_IMM,
      isc_pkg::OP_ADDC_REG: begin
        cycles_d.fetch = isc_pkg::C1;
      end
      isc_pkg::OP_ADD_W_IMM,
      isc_pkg::OP_AND_W_IMM: begin
        cycles_d.fetch = isc_pkg::C2;
      end
      isc_pkg::OP_ADD_L_IMM,
      isc_pkg::OP_AND_L_IMM: begin
        cycles_d.fetch = isc_pkg::C3;
      end
      isc_pkg::OP_ADD_L_REG: begin
        cycles_d.fetch = isc_pkg::C1;
      end
      isc_pkg::OP_AND_L_REG: begin
        cycles_d.fetch = isc_pkg::C2;
      end
      isc_pkg::OP_ADD_SMALL: begin
        cycles_d.fetch = isc_pkg::C1;
      end
      isc_pkg::OP_AND_FLAGS: begin
        cycles_d.fetch = isc_pkg::C1;
      end
      isc_pkg::OP_BITAND_REG,
      isc_pkg::OP_BITCLR_REG: begin
        cycles_d.fetch = isc_pkg::C1;
      end
      isc_pkg::OP_BITAND_IND,
      isc_pkg::OP_BITAND_ABS: begin
        cycles_d.fetch   = isc_pkg::C2;
        cycles_d.byteAcc = isc_pkg::C1;
      end
      isc_pkg::OP_BRANCH_D8: begin
        // Taken or not, the short form costs the same.
        cycles_d.fetch = isc_pkg::C2;
      end
      isc_pkg::OP_BRANCH_D16: begin
        cycles_d.fetch    = isc_pkg::C2;
        cycles_d.internal = isc_pkg::C2;
      end
      isc_pkg::OP_BITCLR_MEM: begin
        // One read and one write-back of the same byte.
        cycles_d.fetch   = isc_pkg::C2;
        cycles_d.byteAcc = isc_pkg::C2;
      end
      default: begin
        // Classes outside the table report zero and flag themselves.
        known_d = 1'b0;
      end
    endcase
  end

  // Stage one registers the decode beside the peripheral lookup.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cycles_q <= '0;
      known_q  <= 1'b0;
      peri_q   <= 1'b0;
      valid1_q <= 1'b0;
    end else begin
      cycles_q <= cycles_d;
      known_q  <= known_d;
      peri_q   <= peri_d;
      valid1_q <= valid1_d;
    end
  end

  // Data cycles weigh by location; the rest by their fixed cost.
  always_comb begin
    if (peri_q) begin
      dataStates = periStates;
    end else begin
      dataStates = isc_pkg::ST_MEMORY;
    end
    weight[isc_pkg::K_FETCH]    = isc_pkg::ST_MEMORY;
    weight[isc_pkg::K_BRADDR]   = isc_pkg::ST_MEMORY;
    weight[isc_pkg::K_STACK]    = isc_pkg::ST_MEMORY;
    weight[isc_pkg::K_BYTE]     = dataStates;
    weight[isc_pkg::K_WORD]     = dataStates;
    weight[isc_pkg::K_INTERNAL] = isc_pkg::ST_INTERNAL;
    count[isc_pkg::K_FETCH]     = cycles_q.fetch;
    count[isc_pkg::K_BRADDR]    = cycles_q.brAddr;
    count[isc_pkg::K_STACK]     = cycles_q.stack;
    count[isc_pkg::K_BYTE]      = cycles_q.byteAcc;
    count[isc_pkg::K_WORD]      = cycles_q.word;
    count[isc_pkg::K_INTERNAL]  = cycles_q.internal;
  end

  // One product per cycle kind; widths kept exact for the sum.
  for (genvar k = 0; k < isc_pkg::KIND_COUNT; k++) begin : gKind
    // Both factors widen first, so a large count cannot wrap the product.
    assign weighted[k] = isc_pkg::TOTAL_W'(count[k])
                         * isc_pkg::TOTAL_W'(weight[k]);
  end

  // Total is the plain sum of all weighted kinds.
  always_comb begin
    sum = '0;
    for (int k = 0; k < isc_pkg::KIND_COUNT; k++) begin
      sum = isc_pkg::TOTAL_W'(sum + weighted[k]);
    end
    res_d.cycles = cycles_q;
    res_d.states = sum;
    res_d.known  = known_q;
    valid2_d     = valid1_q;
  end

  // Stage two registers the answer so outputs come from flip-flops.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      res_q    <= '0;
      valid2_q <= 1'b0;
    end else begin
      res_q    <= res_d;
      valid2_q <= valid2_d;
    end
  end

  assign resValid = valid2_q;
  assign res      = res_q;

endmodule

//--- hdl/isc_pkg.sv
// Purpose: Shared constants and types for the instruction state counter.
// Assumes: One 25 MHz clock; no software-visible registers.
// Notes:   Cycle kinds, instruction classes and access-state weights.
package isc_pkg;

  // Number of distinct bus-cycle kinds.
  localparam int unsigned KIND_COUNT = 6;

  // Width of one cycle count and of the total state count.
  localparam int unsigned CNT_W   = 4;
  localparam int unsigned TOTAL_W = 8;

  // Index of each bus-cycle kind.
  localparam int unsigned K_FETCH   = 0;
  localparam int unsigned K_BRADDR  = 1;
  localparam int unsigned K_STACK   = 2;
  localparam int unsigned K_BYTE    = 3;
  localparam int unsigned K_WORD    = 4;
  localparam int unsigned K_INTERNAL = 5;

  // States per cycle at each location.
  localparam logic [1:0] ST_MEMORY   = 2'h2;
  localparam logic [1:0] ST_PERI_FAST = 2'h2;
  localparam logic [1:0] ST_PERI_SLOW = 2'h3;
  localparam logic [1:0] ST_INTERNAL = 2'h1;

  // Peripheral region decode: the address bits that pick a module.
  localparam int unsigned ADDR_W      = 24;
  localparam int unsigned REGION_HI   = 7;
  localparam int unsigned REGION_LO   = 4;
  localparam int unsigned REGION_N    = 16;
  // One bit per module region: a set bit means three states.
  localparam logic [15:0] SLOW_REGION_MAP = 16'hF0F0;

  // Instruction classes covered by the timing table.
  typedef enum logic [4:0] {
    OP_ADD_B_IMM     = 5'h00,
    OP_ADD_B_REG     = 5'h01,
    OP_ADD_W_IMM     = 5'h02,
    OP_ADD_W_REG     = 5'h03,
    OP_ADD_L_IMM     = 5'h04,
    OP_ADD_L_REG     = 5'h05,
    OP_ADD_SMALL     = 5'h06,
    OP_ADDC_IMM      = 5'h07,
    OP_ADDC_REG      = 5'h08,
    OP_AND_B_IMM     = 5'h09,
    OP_AND_B_REG     = 5'h0A,
    OP_AND_W_IMM     = 5'h0B,
    OP_AND_W_REG     = 5'h0C,
    OP_AND_L_IMM     = 5'h0D,
    OP_AND_L_REG     = 5'h0E,
    OP_AND_FLAGS     = 5'h0F,
    OP_BITAND_REG    = 5'h10,
    OP_BITAND_IND    = 5'h11,
    OP_BITAND_ABS    = 5'h12,
    OP_BRANCH_D8     = 5'h13,
    OP_BRANCH_D16    = 5'h14,
    OP_BITCLR_REG    = 5'h15,
    OP_BITCLR_MEM    = 5'h16
  } isc_op_type;

  // Per-kind cycle counts of one instruction.
  typedef logic [CNT_W-1:0] isc_cnt_type;
  typedef struct packed {
    isc_cnt_type internal;
    isc_cnt_type word;
    isc_cnt_type byteAcc;
    isc_cnt_type stack;
    isc_cnt_type brAddr;
    isc_cnt_type fetch;
  } isc_cycles_type;

  // One request: instruction class plus where its data cycles are served.
  typedef struct packed {
    isc_op_type                op;
    logic                      dataIsPeri;
    logic [ADDR_W-1:0]         dataAddr;
  } isc_req_type;

  // Result: cycle breakdown and total states.
  typedef struct packed {
    isc_cycles_type            cycles;
    logic [TOTAL_W-1:0]        states;
    logic                      known;
  } isc_res_type;

  localparam isc_cnt_type C0 = 4'h0;
  localparam isc_cnt_type C1 = 4'h1;
  localparam isc_cnt_type C2 = 4'h2;
  localparam isc_cnt_type C3 = 4'h3;

endpackage

//--- hdl/isc_peri_lookup.sv
// Purpose: Per-module access state lookup for peripheral data cycles.
// Assumes: Address is stable and from the same clock domain.
// Notes:   Registered result, one cycle after the address.
`timescale 1ns/100ps
module isc_peri_lookup (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic [isc_pkg::ADDR_W-1:0] addr,
  output logic      [1:0]                 accessStates
);

  logic [isc_pkg::REGION_HI-isc_pkg::REGION_LO:0] region;
  logic [1:0] states_d;
  logic [1:0] states_q;

  // Region picks the module; the map says whether it needs a wait state.
  always_comb begin
    region = addr[isc_pkg::REGION_HI:isc_pkg::REGION_LO];
    if (isc_pkg::SLOW_REGION_MAP[region]) begin
      states_d = isc_pkg::ST_PERI_SLOW;
    end else begin
      states_d = isc_pkg::ST_PERI_FAST;
    end
  end

  // Register the lookup so the adder stage sees a clean value.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      states_q <= isc_pkg::ST_PERI_FAST;
    end else begin
      states_q <= states_d;
    end
  end

  assign accessStates = states_q;

endmodule

//--- test/isc_peri_model.sv
// Purpose: Model of the peripheral modules' data access cost.
// Assumes: The module region is picked by address bits 7 to 4.
// Notes:   Kept apart from the design's lookup table on purpose.
`timescale 1ns/100ps
module isc_peri_model (
  input  wire logic [isc_pkg::ADDR_W-1:0] addr,
  output logic      [1:0]                 accessStates
);
  // Regions 4-7 and C-F add a wait state, which is exactly bit 6 set.
  assign accessStates = addr[6] ? 2'h3 : 2'h2;
endmodule

//--- test/isc_state_counter_props.sv
// Purpose: Port timing and count checks for the state counter.
// Assumes: One clock; the answer comes two edges after the taking edge.
// Notes:   Bound to every instance of the state counter.
`timescale 1ns/100ps
module isc_state_counter_props (
  input wire logic                 clk,
  input wire logic                 rst_n,
  input wire logic                 reqValid,
  input wire isc_pkg::isc_req_type req,
  input wire logic                 resValid,
  input wire isc_pkg::isc_res_type res
);
  // Slow region flag of the address now on the request.
  wire logic slowReq = isc_pkg::SLOW_REGION_MAP[req.dataAddr[7:4]];
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Latency, no answer without a request, and the per-class figures.
  chk_ans_latency: assert property (
    reqValid |-> ##2 resValid) else $error("answer late or missing");
  chk_no_extra: assert property (
    resValid |-> $past(reqValid, 2)) else $error("answer without request");
  chk_br_short: assert property (
    reqValid && req.op == isc_pkg::OP_BRANCH_D8 |-> ##2
    res.cycles.fetch == 4'h2 && res.cycles.internal == 4'h0 &&
    res.states == 8'h04) else $error("short branch count wrong");
  chk_br_long: assert property (
    reqValid && req.op == isc_pkg::OP_BRANCH_D16 |-> ##2
    res.cycles.internal == 4'h2 && res.states == 8'h06)
    else $error("long branch count wrong");
  chk_long_imm: assert property (
    reqValid && req.op inside {isc_pkg::OP_ADD_L_IMM, isc_pkg::OP_AND_L_IMM}
    |-> ##2 res.cycles.fetch == 4'h3 && res.states == 8'h06)
    else $error("long immediate count wrong");
  chk_clr_memory: assert property (
    reqValid && req.op == isc_pkg::OP_BITCLR_MEM && !req.dataIsPeri |-> ##2
    res.cycles.byteAcc == 4'h2 && res.states == 8'h08)
    else $error("bit clear in memory count wrong");
  chk_weighted_sum: assert property (
    resValid && res.known && res.cycles.byteAcc == 4'h0 &&
    res.cycles.word == 4'h0 |-> res.states == 8'(2 * (res.cycles.fetch +
    res.cycles.brAddr + res.cycles.stack) + res.cycles.internal))
    else $error("total states not the weighted sum");
  chk_peri_weight: assert property (
    reqValid && req.op == isc_pkg::OP_BITAND_ABS && req.dataIsPeri |-> ##2
    res.states == ($past(slowReq, 2) ? 8'h07 : 8'h06))
    else $error("peripheral access weight wrong");
endmodule
bind isc_state_counter isc_state_counter_props uChk (.clk(clk),
  .rst_n(rst_n), .reqValid(reqValid), .req(req), .resValid(resValid),
  .res(res));

//--- test/isc_state_counter_tb.sv
// Purpose: Self-checking bench for the instruction state counter.
// Assumes: Answer two cycles after the taking edge, one cycle wide.
// Notes:   Expectations are rebuilt here from the cycle table.
`timescale 1ns/100ps
module isc_state_counter_tb;
  logic                 clk = 1'b0;
  logic                 rst_n = 1'b0;
  logic                 reqValid = 1'b0;
  isc_pkg::isc_req_type req = '0;
  logic                 resValid;
  isc_pkg::isc_res_type res;
  logic [1:0]           periStates;
  int                   bad_count = 0;
  int                   samples_checked = 0;

  // Clock and the design with its peripheral partner.
  always #20 clk = ~clk;
  isc_state_counter DUT (.clk(clk), .rst_n(rst_n), .reqValid(reqValid),
    .req(req), .resValid(resValid), .res(res));
  isc_peri_model PERI (.addr(req.dataAddr), .accessStates(periStates));

  // Compare and count; widths are padded to one byte.
  task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Drive one request just after an edge; held until the next edge.
  task automatic put(logic [4:0] op, logic peri, logic [7:0] addr);
    @(posedge clk);
    reqValid <= 1'b1;
    req <= '{isc_pkg::isc_op_type'(op), peri, 24'(addr)};
  endtask

  // Judge the answer in mid-cycle, once the result edge has settled.
  task automatic expect_res(logic [4:0] op, logic peri);
    logic [3:0] f;
    logic [3:0] b;
    logic [3:0] n;
    @(negedge clk);
    f = (op inside {5'h02, 5'h0B, 5'h0E, 5'h11, 5'h12, 5'h13, 5'h14,
      5'h16}) ? 4'h2 : (op inside {5'h04, 5'h0D}) ? 4'h3 : 4'h1;
    if (op > 5'h16) f = 4'h0;
    b = (op == 5'h16) ? 4'h2 : (op inside {5'h11, 5'h12}) ? 4'h1 : 4'h0;
    n = (op == 5'h14) ? 4'h2 : 4'h0;
    check("resValid", 8'(resValid), 8'h01);
    check("known", 8'(res.known), 8'(op <= 5'h16));
    check("fetch", 8'(res.cycles.fetch), 8'(f));
    check("byte", 8'(res.cycles.byteAcc), 8'(b));
    check("internal", 8'(res.cycles.internal), 8'(n));
    check("word", 8'(res.cycles.word), 8'h00);
    check("brAddr", 8'(res.cycles.brAddr), 8'h00);
    check("stack", 8'(res.cycles.stack), 8'h00);
    check("states", res.states,
      8'(2 * f + n + b * (peri ? periStates : 2'h2)));
  endtask

  // One isolated request followed by its answer.
  task automatic one(logic [4:0] op, logic peri, logic [7:0] addr);
    put(op, peri, addr);
    @(posedge clk) reqValid <= 1'b0;
    @(posedge clk);
    expect_res(op, peri);
  endtask

  // Every class in memory, plus one code past the end of the table.
  task automatic test_table();
    for (int i = 0; i < 24; i++) one(5'(i), 1'b0, 8'h00);
    $display("test_table done");
  endtask

  // Byte accesses to all sixteen peripheral regions, both kinds.
  task automatic test_peri();
    for (int r = 0; r < 32; r++)
      one(r[0] ? 5'h16 : 5'h12, 1'b1, {r[4:1], 4'h5});
    $display("test_peri done");
  endtask

  // Two requests on consecutive edges, then a quiet cycle.
  task automatic test_b2b();
    put(5'h14, 1'b0, 8'h00);
    put(5'h0E, 1'b0, 8'h00);
    @(posedge clk) reqValid <= 1'b0;
    expect_res(5'h14, 1'b0);
    expect_res(5'h0E, 1'b0);
    @(negedge clk);
    check("resValid low", 8'(resValid), 8'h00);
    $display("test_b2b done");
  endtask

  // Reset with a request in flight drops its answer and clears outputs.
  task automatic test_reset();
    put(5'h14, 1'b0, 8'h00);
    @(posedge clk);
    reqValid <= 1'b0;
    rst_n <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    check("resValid in reset", 8'(resValid), 8'h00);
    check("states in reset", res.states, 8'h00);
    @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    check("resValid after reset", 8'(resValid), 8'h00);
    check("fetch after reset", 8'(res.cycles.fetch), 8'h00);
    one(5'h13, 1'b0, 8'h00);
    $display("test_reset done");
  endtask

  // Counts, verdict and end of run.
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Main sequence after four cycles of reset.
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    test_table();
    test_peri();
    test_b2b();
    test_reset();
    print_verdict();
  end

  // Watchdog: the tests need well under 300 cycles.
  initial begin
    repeat (2000) @(posedge clk);
    bad_count++;
    print_verdict();
  end
endmodule
